// >>> ncs_pkg.sv
// Constants and types shared by the cell charge sequencer
package ncs_pkg;

  // ****************************************************************
  // Clock and time base
  // ****************************************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 1000;
  // Fine time base: one tick per millisecond
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int TICKS_PER_S = 1_000_000 / TICK_US;

  // ****************************************************************
  // Sequencer times, each in its own unit, then in ticks
  // ****************************************************************
  localparam int CTST_S = 31;
  localparam int CTST_TICKS = CTST_S * TICKS_PER_S;
  localparam int PCHG_MIN = 30;
  localparam int PCHG_TICKS = PCHG_MIN * 60 * TICKS_PER_S;
  localparam int THO_MIN = 4;
  localparam int THO_TICKS = THO_MIN * 60 * TICKS_PER_S;
  localparam int FLAT_MIN = 16;
  localparam int FLAT_TICKS = FLAT_MIN * 60 * TICKS_PER_S;
  // Length of one cell test with the switch held off
  localparam int TEST_TICKS = 8;

  // ****************************************************************
  // Status indicator rates
  // ****************************************************************
  localparam int SLOW_HZ = 1;
  localparam int FAST_HZ = 4;
  localparam int BLINK_TICKS = TICKS_PER_S / SLOW_HZ;
  localparam int SLOW_HALF = BLINK_TICKS / 2;
  localparam int FAST_PER = TICKS_PER_S / FAST_HZ;
  localparam int FAST_HALF = FAST_PER / 2;

  // ****************************************************************
  // Pass-switch duty cycles over a 64-tick frame
  // ****************************************************************
  localparam int PWM_W = 6;
  localparam logic [PWM_W-1:0] DF_QUARTER_ON = 6'h10;
  localparam logic [PWM_W-1:0] DF_MAINT_ON = 6'h01;

  // ****************************************************************
  // Cell readings, charge timer and watchdog
  // ****************************************************************
  localparam int VW = 12;
  // Reading LSB is 1 mV
  localparam logic [VW-1:0] NDV_COUNTS = 12'h002;
  localparam int CTMR_EDGES = 3600;
  localparam int TW = 31;
  localparam int WD_W = 8;
  localparam logic [WD_W-1:0] WD_LIMIT = 8'h10;

  typedef enum logic [3:0] {
    NCS_POR, NCS_PRESENCE, NCS_PRECHARGE, NCS_FAST, NCS_CELL_TEST,
    NCS_TOPOFF, NCS_MAINT, NCS_FAULT, NCS_SUSPEND
  } ncs_state_t;

endpackage

// >>> ncs_watchdog.sv
// Watchdog that stops charging when the main time base stalls
`timescale 1ns/1ps
module ncs_watchdog
  import ncs_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wd_edge_i,
  input wire logic tick_i,
  output logic halt_o
);

  logic [WD_W-1:0] cnt_r;
  logic [WD_W-1:0] cnt_nxt;
  logic halt_r;
  logic halt_nxt;

  // Too many watchdog-oscillator edges without a main tick means the
  // main time base has stopped; the halt holds until reset
  always_comb
  begin
    cnt_nxt = cnt_r;
    halt_nxt = halt_r;
    if (tick_i)
      cnt_nxt = '0;
    else if (wd_edge_i && cnt_r != WD_LIMIT)
      cnt_nxt = cnt_r + 8'h01;
    if (cnt_r == WD_LIMIT)
      halt_nxt = 1'b1; // [RULE22]
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_r <= '0;
      halt_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      halt_r <= halt_nxt;
    end
  end

  assign halt_o = halt_r;

endmodule

// >>> ncs_charger.sv
// Charge sequencer for a single rechargeable cell
`timescale 1ns/1ps

// What this block does
// RULE1: Reinitialise on power-up and on leaving suspend, then wait in presence.
// RULE2: Undervoltage lockout blocks charging, holds power-on state, clears timers.
// RULE3: Enter presence when timer resistor connected and supply above lockout.
// RULE4: Presence to precharge only on cell below 1.65V and temperature 0-45C.
// RULE5: Precharge gates sense loop at 25% duty, status blinks at 1Hz.
// RULE6: Precharge goes to fast charge once cell exceeds 1.0V.
// RULE7: Precharge faults on 30min timeout, over 50C, or cell above 1.75V.
// RULE8: Fast charge runs sense loop continuously with status held high.
// RULE9: Cell test every 31s with pass switch held off throughout.
// RULE10: Fast charge goes to top-off when resistor-set charge timer expires.
// RULE11: Over 50C during fast charge stops charging, goes to maintenance.
// RULE12: Charging overvoltage during fast charge goes to fault.
// RULE13: Track peak test reading; drop over 2mV below peak ends fast charge.
// RULE14: No new peak for 16min also ends fast charge.
// RULE15: Negative-delta and flat termination suppressed for first 4min.
// RULE16: Loaded minus open-circuit reading above impedance threshold faults.
// RULE17: Any cell-test reading above open overvoltage limit faults.
// RULE18: Top-off charges at 25%, status high, timer restarted at half.
// RULE19: Top-off goes to maintenance on timer expiry or over 50C.
// RULE20: Top-off faults on overvoltage against limit matching switch state.
// RULE21: Floating timer resistor halts charging and suspends from any state.
// RULE22: Independently clocked watchdog halts charging if main time base stops.
// RULE23: Maintenance charges at 1.56% with status low until cell removed.
// RULE24: Fault holds switch off and blinks status at 4Hz, 50% duty.
// RULE25: Fault exits to presence only when cell reads above 1.75V.
// RULE26: Restoring timer resistor after suspend restarts with timers cleared.
module ncs_charger
  import ncs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int CTST_T = CTST_TICKS,
  parameter int PCHG_T = PCHG_TICKS,
  parameter int THO_T = THO_TICKS,
  parameter int FLAT_T = FLAT_TICKS,
  parameter int CTMR_E = CTMR_EDGES
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic undervoltage_lockout_i,
  input wire logic timer_resistor_float_i,
  input wire logic cell_over_depleted_i,
  input wire logic cell_over_open_i,
  input wire logic cell_over_charge_i,
  input wire logic temp_in_range_i,
  input wire logic temp_hot_stop_i,
  input wire logic sense_below_ref_i,
  input wire logic [VW-1:0] cell_voltage_sense_i,
  input wire logic [VW-1:0] impedance_threshold_i,
  input wire logic charge_osc_i,
  input wire logic watchdog_osc_i,
  output logic charge_switch_o,
  output logic status_o,
  output logic watchdog_halt_o
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NB = 11;
  localparam int NS = NB + 2 * VW;

  // The readings are taken as settled while captured; a reading that
  // moves during the capture edge may tear across the two stages
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  logic [1:0] osc_d_r;
  logic lowv;
  logic floating;
  logic over_dep;
  logic over_open;
  logic over_chg;
  logic temp_ok;
  logic hot;
  logic sense_lo;
  logic [VW-1:0] reading;
  logic [VW-1:0] imp_thr;
  logic ctmr_edge;
  logic wd_edge;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      osc_d_r <= '0;
    end
    else
    begin
      s1_r <= {impedance_threshold_i, cell_voltage_sense_i,
               watchdog_osc_i, charge_osc_i, sense_below_ref_i,
               temp_hot_stop_i, temp_in_range_i, cell_over_charge_i,
               cell_over_open_i, cell_over_depleted_i,
               timer_resistor_float_i, undervoltage_lockout_i,
               1'b0};
      s2_r <= s1_r;
      osc_d_r <= s2_r[10:9];
    end
  end

  assign lowv = s2_r[1];
  assign floating = s2_r[2];
  assign over_dep = s2_r[3];
  assign over_open = s2_r[4];
  assign over_chg = s2_r[5];
  assign temp_ok = s2_r[6];
  assign hot = s2_r[7];
  assign sense_lo = s2_r[8];
  assign ctmr_edge = s2_r[9] & ~osc_d_r[0];
  assign wd_edge = s2_r[10] & ~osc_d_r[1];
  assign reading = s2_r[NB+VW-1:NB];
  assign imp_thr = s2_r[NS-1:NB+VW];

  function automatic logic [TW-1:0] inc_sat(input logic [TW-1:0] x);
    inc_sat = (&x) ? x : x + 31'h1;
  endfunction

  // ****************************************************************
  // Time base, duty frame and indicator phase
  // ****************************************************************
  logic [TW-1:0] div_r;
  logic [TW-1:0] div_nxt;
  logic tick_r;
  logic tick_nxt;
  logic [PWM_W-1:0] pwm_r;
  logic [PWM_W-1:0] pwm_nxt;
  logic [TW-1:0] blink_r;
  logic [TW-1:0] blink_nxt;

  always_comb
  begin
    tick_nxt = (div_r == TW'(TICK_CYC - 1));
    div_nxt = tick_nxt ? '0 : div_r + 31'h1;
    pwm_nxt = tick_r ? pwm_r + 6'h01 : pwm_r;
    blink_nxt = blink_r;
    if (tick_r)
      blink_nxt = (blink_r == TW'(BLINK_TICKS - 1)) ? '0 : blink_r + 31'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      div_r <= '0;
      tick_r <= 1'b0;
      pwm_r <= '0;
      blink_r <= '0;
    end
    else
    begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      pwm_r <= pwm_nxt;
      blink_r <= blink_nxt;
    end
  end

  // ****************************************************************
  // Watchdog on an independent oscillator
  // ****************************************************************
  logic wd_halt;

  ncs_watchdog u_wd (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wd_edge_i(wd_edge),
    .tick_i(tick_r),
    .halt_o(wd_halt)
  );

  // ****************************************************************
  // Charge sequencer
  // ****************************************************************
  ncs_state_t st_r;
  ncs_state_t st_nxt;
  logic [TW-1:0] age_r;
  logic [TW-1:0] age_nxt;
  logic [TW-1:0] hold_r;
  logic [TW-1:0] hold_nxt;
  logic [TW-1:0] ctst_r;
  logic [TW-1:0] ctst_nxt;
  logic [TW-1:0] flat_r;
  logic [TW-1:0] flat_nxt;
  logic [TW-1:0] ctmr_r;
  logic [TW-1:0] ctmr_nxt;
  logic [VW-1:0] peak_r;
  logic [VW-1:0] peak_nxt;
  logic [VW-1:0] load_r;
  logic [VW-1:0] load_nxt;
  logic quarter_on;
  logic held_off;

  assign quarter_on = (pwm_r < DF_QUARTER_ON);
  assign held_off = (hold_r >= TW'(THO_T));

  always_comb
  begin
    st_nxt = st_r;
    age_nxt = tick_r ? inc_sat(age_r) : age_r;
    hold_nxt = hold_r;
    ctst_nxt = ctst_r;
    flat_nxt = flat_r;
    ctmr_nxt = ctmr_edge ? inc_sat(ctmr_r) : ctmr_r;
    peak_nxt = peak_r;
    load_nxt = load_r;
    if (tick_r && (st_r == NCS_FAST || st_r == NCS_CELL_TEST))
    begin
      hold_nxt = inc_sat(hold_r);
      flat_nxt = inc_sat(flat_r);
      ctst_nxt = inc_sat(ctst_r);
    end
    unique case (st_r)
      NCS_POR:
        st_nxt = NCS_PRESENCE; // [RULE1] [RULE3]
      NCS_PRESENCE:
        if (!over_open && temp_ok)
          st_nxt = NCS_PRECHARGE; // [RULE4]
      NCS_PRECHARGE:
        if (over_chg || hot)
          st_nxt = NCS_FAULT; // [RULE7]
        else if (over_dep)
          st_nxt = NCS_FAST; // [RULE6]
        else if (age_r >= TW'(PCHG_T))
          st_nxt = NCS_FAULT; // [RULE7]
      NCS_FAST:
        if (over_chg)
          st_nxt = NCS_FAULT; // [RULE12]
        else if (hot)
          st_nxt = NCS_MAINT; // [RULE11]
        else if (ctmr_r >= TW'(CTMR_E))
          st_nxt = NCS_TOPOFF; // [RULE10]
        else if (ctst_r >= TW'(CTST_T))
        begin
          st_nxt = NCS_CELL_TEST; // [RULE9]
          load_nxt = reading;
        end
      NCS_CELL_TEST:
        if (over_open)
          st_nxt = NCS_FAULT; // [RULE17]
        else if (hot)
          st_nxt = NCS_MAINT; // [RULE11]
        else if (tick_r && age_r >= TW'(TEST_TICKS - 1))
        begin
          ctst_nxt = '0;
          if (load_r > reading && load_r - reading > imp_thr)
            st_nxt = NCS_FAULT; // [RULE16]
          else if (held_off && peak_r > reading &&
                   peak_r - reading > NDV_COUNTS)
            st_nxt = NCS_TOPOFF; // [RULE13] [RULE15]
          else if (held_off && flat_r >= TW'(FLAT_T))
            st_nxt = NCS_TOPOFF; // [RULE14] [RULE15]
          else
            st_nxt = NCS_FAST;
          if (reading > peak_r)
          begin
            peak_nxt = reading; // [RULE13]
            flat_nxt = '0; // [RULE14]
          end
        end
      NCS_TOPOFF:
        if ((quarter_on && over_chg) || (!quarter_on && over_open))
          st_nxt = NCS_FAULT; // [RULE20]
        else if (hot || ctmr_r >= TW'(CTMR_E / 2))
          st_nxt = NCS_MAINT; // [RULE19]
      NCS_MAINT:
        if (over_chg)
          st_nxt = NCS_PRESENCE; // [RULE23]
      NCS_FAULT:
        if (over_chg)
          st_nxt = NCS_PRESENCE; // [RULE25]
      NCS_SUSPEND:
        st_nxt = NCS_POR; // [RULE1] [RULE26]
      default:
        st_nxt = NCS_POR;
    endcase
    // Suspend and lockout override every state; lockout wins
    if (floating)
      st_nxt = NCS_SUSPEND; // [RULE21]
    if (lowv)
      st_nxt = NCS_POR; // [RULE2]
    if (st_nxt != st_r)
      age_nxt = '0;
    if (st_nxt == NCS_TOPOFF && st_r != NCS_TOPOFF)
      ctmr_nxt = '0; // [RULE18]
    // Fast-charge timers stay idle and cleared until fast charge starts; age_r still runs
    if (st_nxt == NCS_POR || st_nxt == NCS_PRESENCE ||
        st_nxt == NCS_SUSPEND || st_nxt == NCS_PRECHARGE)
    begin
      hold_nxt = '0; // [RULE2] [RULE26]
      ctst_nxt = '0;
      flat_nxt = '0;
      ctmr_nxt = '0;
      peak_nxt = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= NCS_POR;
      age_r <= '0;
      hold_r <= '0;
      ctst_r <= '0;
      flat_r <= '0;
      ctmr_r <= '0;
      peak_r <= '0;
      load_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      age_r <= age_nxt;
      hold_r <= hold_nxt;
      ctst_r <= ctst_nxt;
      flat_r <= flat_nxt;
      ctmr_r <= ctmr_nxt;
      peak_r <= peak_nxt;
      load_r <= load_nxt;
    end
  end

  // ****************************************************************
  // Pass switch and status indicator
  // ****************************************************************
  logic cs_r;
  logic cs_nxt;
  logic status_r;
  logic status_nxt;
  logic gate_on;

  // The hysteretic sense comparator does the regulating; the sequencer
  // only opens the window in which it may switch the pass device on
  always_comb
  begin
    gate_on = 1'b0;
    status_nxt = 1'b0;
    unique case (st_r)
      NCS_PRECHARGE:
      begin
        gate_on = quarter_on; // [RULE5]
        status_nxt = (blink_r < TW'(SLOW_HALF)); // [RULE5]
      end
      NCS_FAST:
      begin
        gate_on = 1'b1; // [RULE8]
        status_nxt = 1'b1; // [RULE8]
      end
      NCS_CELL_TEST:
      begin
        gate_on = 1'b0; // [RULE9]
        status_nxt = 1'b1;
      end
      NCS_TOPOFF:
      begin
        gate_on = quarter_on; // [RULE18]
        status_nxt = 1'b1; // [RULE18]
      end
      NCS_MAINT:
        gate_on = (pwm_r < DF_MAINT_ON); // [RULE23]
      NCS_FAULT:
        status_nxt = ((blink_r % TW'(FAST_PER)) < TW'(FAST_HALF)); // [RULE24]
      NCS_POR, NCS_PRESENCE, NCS_SUSPEND:
        gate_on = 1'b0; // [RULE2] [RULE21]
      default:
        gate_on = 1'b0;
    endcase
    // Switch is active low: high keeps the cell from charging
    cs_nxt = ~(gate_on && sense_lo && !wd_halt && !lowv); // [RULE22] [RULE24]
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cs_r <= 1'b1;
      status_r <= 1'b0;
    end
    else
    begin
      cs_r <= cs_nxt;
      status_r <= status_nxt;
    end
  end

  assign charge_switch_o = cs_r;
  assign status_o = status_r;
  assign watchdog_halt_o = wd_halt;

endmodule

// >>> ncs_charger_asserts.sv
// Port-level checks on the cell charge sequencer
`timescale 1ns/1ps
module ncs_charger_chk (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic undervoltage_lockout_i,
  input wire logic timer_resistor_float_i,
  input wire logic cell_over_open_i,
  input wire logic cell_over_charge_i,
  input wire logic sense_below_ref_i,
  input wire logic charge_switch_o,
  input wire logic status_o,
  input wire logic watchdog_halt_o
);
  // ****************************************************************
  // Run of switch-on cycles with the indicator dark
  // ****************************************************************
  logic [8:0] low_run_r;
  logic [8:0] low_run_nxt;
  always_comb
  begin
    low_run_nxt = 9'h000;
    if (!charge_switch_o && !status_o)
      low_run_nxt = low_run_r + 9'h001;
  end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      low_run_r <= 9'h000;
    else
      low_run_r <= low_run_nxt;
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_reset_idle: assert property (
    $fell(sys_rst_i) |-> charge_switch_o && !status_o && !watchdog_halt_o)
    else $error("outputs not idle after reset");
  a_lockout_off: assert property (
    undervoltage_lockout_i [*5] |-> charge_switch_o)
    else $error("switch on during lockout");
  a_lockout_dark: assert property (
    undervoltage_lockout_i [*6] |-> !status_o)
    else $error("status lit during lockout");
  a_float_off: assert property (
    timer_resistor_float_i [*6] |-> charge_switch_o)
    else $error("switch on while timer input floats");
  a_wd_quiet: assert property (
    !watchdog_halt_o)
    else $error("watchdog halted with main clock running");
  // Sense gating is only claimed where the indicator is lit
  a_sense_gate: assert property (
    (!sense_below_ref_i && status_o) [*5] |-> charge_switch_o)
    else $error("switch on with sense above reference");
  a_cell_gone: assert property (
    (cell_over_charge_i && cell_over_open_i && !undervoltage_lockout_i
      && !timer_resistor_float_i) [*8] |-> charge_switch_o && !status_o)
    else $error("no return to idle after cell removal");
  // Longest dark on-window is the sixteen-tick precharge slot
  a_low_run: assert property (
    low_run_r <= 9'h0a0)
    else $error("switch on window too long");
  c_switch_on: cover property ($fell(charge_switch_o));
  c_status_on: cover property ($rose(status_o));
  c_removal: cover property (cell_over_charge_i ##8 !status_o);
endmodule

bind ncs_charger ncs_charger_chk ncs_charger_chk_inst (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .undervoltage_lockout_i(undervoltage_lockout_i),
  .timer_resistor_float_i(timer_resistor_float_i),
  .cell_over_open_i(cell_over_open_i),
  .cell_over_charge_i(cell_over_charge_i),
  .sense_below_ref_i(sense_below_ref_i),
  .charge_switch_o(charge_switch_o),
  .status_o(status_o),
  .watchdog_halt_o(watchdog_halt_o)
);

// >>> ncs_cell_model.sv
// Behavioural model of the charge-timer and watchdog oscillators
`timescale 1ns/1ps
module ncs_cell_model (
  input wire logic clk_i,
  input wire logic timer_run_i,
  output logic charge_osc_o,
  output logic watchdog_osc_o
);
  int chg_n = 0;
  int wd_n = 0;
  initial
  begin
    charge_osc_o = 1'b0;
    watchdog_osc_o = 1'b0;
  end
  // Timer can be frozen so other terminations are seen on their own
  always @(posedge clk_i)
  begin
    if (timer_run_i)
      chg_n <= (chg_n + 1) % 100;
    if (timer_run_i && chg_n == 99)
      charge_osc_o <= ~charge_osc_o;
    wd_n <= (wd_n + 1) % 25;
    if (wd_n == 24)
      watchdog_osc_o <= ~watchdog_osc_o;
  end
endmodule

// >>> tb.sv
// Self-checking bench for the cell charge sequencer
`timescale 1ns/1ps
module tb;
  import ncs_pkg::*;
  localparam int TK = 10;
  logic clk_i;
  logic rst = 1'b1;
  logic lock = 1'b1;
  logic flt = 1'b0;
  logic dep = 1'b0;
  logic opn = 1'b1;
  logic ovc = 1'b0;
  logic tin = 1'b1;
  logic hot = 1'b0;
  logic sen = 1'b1;
  logic run = 1'b1;
  logic [VW-1:0] cv = 12'h400;
  logic [VW-1:0] cv_b = 12'h400;
  logic [VW-1:0] imp = 12'hfff;
  logic co, wo, sw, st, wdh, win_m;
  logic [31:0] rng = 32'h2c86df79;
  logic [15:0] exp_q[$];
  logic [15:0] w;
  int lo_n;
  int hi_n;
  int miscompares = 0;
  int checks = 0;
  event probe;

  ncs_charger #(.TICK_CYC(TK), .CTST_T(40), .PCHG_T(200), .THO_T(100),
    .FLAT_T(400), .CTMR_E(20)) ncs_charger_inst (
    .clk_i(clk_i), .sys_rst_i(rst), .undervoltage_lockout_i(lock),
    .timer_resistor_float_i(flt), .cell_over_depleted_i(dep),
    .cell_over_open_i(opn), .cell_over_charge_i(ovc),
    .temp_in_range_i(tin), .temp_hot_stop_i(hot),
    .sense_below_ref_i(sen), .cell_voltage_sense_i(cv),
    .impedance_threshold_i(imp), .charge_osc_i(co),
    .watchdog_osc_i(wo), .charge_switch_o(sw), .status_o(st),
    .watchdog_halt_o(wdh));
  ncs_cell_model ncs_cell_model_inst (.clk_i(clk_i), .timer_run_i(run),
    .charge_osc_o(co), .watchdog_osc_o(wo));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, want);
    end
  endtask

  task report_and_stop();
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Note expected switch and status levels for the monitor
  task out(input logic [1:0] e);
    exp_q.push_back({14'h0, e});
    win_m = 1'b0;
    -> probe;
    cyc(1);
  endtask

  // Count on-cycles and lit cycles; 16'hffff leaves status unjudged
  task win(input int n, input logic [15:0] lo, input logic [15:0] hi);
    lo_n = 0;
    hi_n = 0;
    cyc(n);
    exp_q.push_back(lo);
    exp_q.push_back(hi);
    win_m = 1'b1;
    -> probe;
    cyc(1);
  endtask

  task wait_sw(input logic v, input int lim);
    int i;
    i = 0;
    while (sw !== v && i < lim)
    begin
      cyc(1);
      i++;
    end
    check({15'h0, sw}, {15'h0, v});
  endtask

  task to_fast();
    cv_b = cv_b + 12'h040;
    cv = cv_b;
    opn = 1'b0;
    cyc(10);
    dep = 1'b1;
    cyc(10);
  endtask

  task remove();
    opn = 1'b1;
    ovc = 1'b1;
    cyc(10);
    out(2'b10);
    ovc = 1'b0;
    dep = 1'b0;
    hot = 1'b0;
    cyc(5);
  endtask

  always @(posedge clk_i)
  begin
    lo_n <= lo_n + int'(sw === 1'b0);
    hi_n <= hi_n + int'(st === 1'b1);
  end

  always @(probe)
  begin
    #1;
    w = exp_q.pop_front();
    if (win_m)
    begin
      check(16'(lo_n), w);
      w = exp_q.pop_front();
      if (w !== 16'hffff)
        check(16'(hi_n), w);
    end
    else
      check({14'h0, sw, st}, w);
  end

  initial
  begin
    #600000;
    miscompares++;
    report_and_stop();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    rng = xs(rng);
    cv_b = 12'h400 + {4'h0, rng[7:0]};
    cyc(3);
    rst = 1'b0;
    cyc(10);
    out(2'b10);
    opn = 1'b0;
    cyc(10);
    out(2'b10);
    opn = 1'b1;
    lock = 1'b0;
    cyc(10);
    out(2'b10);
    tin = 1'b0;
    opn = 1'b0;
    cyc(20);
    out(2'b10);
    tin = 1'b1;
    cyc(10);
    win(64 * TK, 16 * TK, 16'hffff);
    cyc(1500);
    win(FAST_PER * TK, 0, FAST_HALF * TK);
    remove();
    opn = 1'b0;
    cyc(10);
    hot = 1'b1;
    cyc(10);
    win(FAST_PER * TK, 0, FAST_HALF * TK);
    remove();
    // Full charge ending on a voltage drop after the holdoff
    to_fast();
    out(2'b01);
    // Sense above reference must keep the switch off while fast charging
    sen = 1'b0;
    cyc(10);
    out(2'b11);
    sen = 1'b1;
    cyc(5);
    wait_sw(1'b1, 600);
    cyc(40);
    out(2'b11);
    wait_sw(1'b0, 100);
    cv = cv - 12'h003;
    wait_sw(1'b1, 600);
    wait_sw(1'b0, 100);
    win(200, 200, 200);
    wait_sw(1'b1, 600);
    cyc(100);
    win(64 * TK, 16 * TK, 64 * TK);
    cyc(1600);
    win(64 * TK, TK, 0);
    remove();
    to_fast();
    hot = 1'b1;
    cyc(10);
    win(64 * TK, TK, 0);
    remove();
    // One-cycle overvoltage while fast charging; fault must latch
    to_fast();
    ovc = 1'b1;
    cyc(1);
    ovc = 1'b0;
    cyc(10);
    win(FAST_PER * TK, 0, FAST_HALF * TK);
    remove();
    // Open-circuit overvoltage seen inside a cell test
    to_fast();
    wait_sw(1'b1, 600);
    opn = 1'b1;
    cyc(20);
    win(FAST_PER * TK, 0, FAST_HALF * TK);
    remove();
    // Reading sags during a test by more than the threshold
    imp = 12'h010 + {8'h0, rng[11:8]};
    to_fast();
    wait_sw(1'b1, 600);
    cyc(20);
    cv = cv - imp - 12'h001;
    cyc(100);
    win(FAST_PER * TK, 0, FAST_HALF * TK);
    remove();
    imp = 12'hfff;
    to_fast();
    flt = 1'b1;
    cyc(10);
    win(100, 0, 16'hffff);
    dep = 1'b0;
    flt = 1'b0;
    cyc(10);
    win(64 * TK, 16 * TK, 16'hffff);
    remove();
    // Charge timer frozen, so only the flat timeout can end fast charge
    run = 1'b0;
    to_fast();
    cyc(5400);
    win(64 * TK, 16 * TK, 64 * TK);
    remove();
    run = 1'b1;
    to_fast();
    cyc(4300);
    win(64 * TK, 16 * TK, 64 * TK);
    remove();
    check({15'h0, wdh}, 16'h0000);
    report_and_stop();
  end
endmodule
